// *** logic/can_cfg_pkg.sv ***
// Package: register map, field layouts, reset values and frame constants of the config block
package can_cfg_pkg;

  // Core clock rate, used to turn microsecond figures into cycle counts
  localparam int CLK_MHZ = 20;

  // Register addresses on the serial register interface
  localparam logic [11:0] ADDR_BUS_CFG = 12'h041;
  localparam logic [11:0] ADDR_SYS_CFG = 12'h046;
  localparam logic [11:0] ADDR_BUS_STAT = 12'h072;

  // Writable bit masks and reset values after startup
  localparam logic [7:0] SYS_CFG_MASK = 8'h0F;
  localparam logic [7:0] SYS_CFG_RESET = 8'h02;
  localparam logic [7:0] BUS_CFG_MASK = 8'h33;
  localparam logic [7:0] BUS_CFG_SEC_BIT = 8'h10;
  localparam logic [7:0] BUS_CFG_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Serial frame: 12 address bits, 3 pad bits, read flag, then 8 data bits
  localparam logic [4:0] FRAME_HDR_BITS = 5'h10;
  localparam logic [4:0] FRAME_ALL_BITS = 5'h18;

  // Stuck-level detector channels
  localparam int DET_SILENCE = 0;
  localparam int DET_BUS = 1;
  localparam int DET_TX = 2;
  localparam int DET_TX2 = 3;
  localparam int DET_N = 4;

  // System configuration layout
  typedef struct packed {
    logic [3:0] unused;
    logic batteryClampDisable;
    logic receivePinIrqSelect;
    logic longUvTimeoutSelect;
    logic supplyArrangementSelect;
  } sys_cfg_t;

  // Bus configuration layout
  typedef struct packed {
    logic [1:0] unusedHi;
    logic localLoopbackEnable;
    logic secondaryLoopbackEnable;
    logic [1:0] unusedLo;
    logic lowPowerListenEnable;
    logic wakePatternSelect;
  } bus_cfg_t;

  // Bus status layout
  typedef struct packed {
    logic readyToTransmit;
    logic [2:0] unused;
    logic busSilenceFlag;
    logic busClampedFlag;
    logic secondaryTxClampedFlag;
    logic primaryTxClampedFlag;
  } bus_stat_t;

  // One register access decoded from a serial frame
  typedef struct packed {
    logic [11:0] addr;
    logic isRead;
    logic [7:0] data;
  } reg_access_t;

endpackage : can_cfg_pkg

// *** logic/spi_frame_slave.sv ***
// Serial register interface slave: samples the pins on the core clock and decodes frames
`timescale 1ns/10ps
module spi_frame_slave (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sckPin,
  input wire logic csPin_n,
  input wire logic mosiPin,
  input wire logic [7:0] rdData,
  output can_cfg_pkg::reg_access_t access,
  output logic writeStb,
  output logic misoOut,
  output logic misoOe
);
  import can_cfg_pkg::*;

  logic [2:0] sckSync;
  logic [1:0] csSync;
  logic [1:0] mosiSync;
  logic [4:0] bitCount;
  logic [23:0] shiftIn;
  logic [7:0] shiftOut;
  logic [4:0] next_bitCount;
  logic [23:0] next_shiftIn;
  logic [7:0] next_shiftOut;
  reg_access_t next_access;
  logic next_writeStb;
  logic next_misoOut;
  logic next_misoOe;
  logic sckRise;
  logic sckFall;
  logic selected;

  // Two-stage synchronisers; edge detection looks only at stage two and beyond
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sckSync <= '0;
      csSync <= 2'b11;
      mosiSync <= '0;
    end else begin
      sckSync <= {sckSync[1:0], sckPin};
      csSync <= {csSync[0], csPin_n};
      mosiSync <= {mosiSync[0], mosiPin};
    end
  end

  assign sckRise = sckSync[1] & ~sckSync[2];
  assign sckFall = ~sckSync[1] & sckSync[2];
  assign selected = ~csSync[1];

  // Frame decode: sample on rising edges, shift reply out on falling edges
  always_comb begin
    next_bitCount = bitCount;
    next_shiftIn = shiftIn;
    next_shiftOut = shiftOut;
    next_access = access;
    next_writeStb = 1'b0;
    next_misoOut = misoOut;
    next_misoOe = selected;
    if (!selected) begin
      next_bitCount = '0;
      next_misoOut = 1'b0;
    end else if (sckRise) begin
      next_shiftIn = {shiftIn[22:0], mosiSync[1]};
      if (bitCount != FRAME_ALL_BITS) begin
        next_bitCount = bitCount + 5'h01;
      end
      if (bitCount == FRAME_HDR_BITS - 5'h01) begin
        // Header complete: latch address and read flag for the register decoder
        next_access.addr = shiftIn[14:3];
        next_access.isRead = mosiSync[1];
      end
      if (bitCount == FRAME_ALL_BITS - 5'h01) begin
        // Extra bits past the frame are ignored rather than starting a new access
        next_access.data = {shiftIn[6:0], mosiSync[1]};
        next_writeStb = ~access.isRead;
      end
    end else if (sckFall && bitCount >= FRAME_HDR_BITS) begin
      if (bitCount == FRAME_HDR_BITS) begin
        // Read data is taken here, once the new address has reached the decoder;
        // loading at the header edge would return the previous frame's register
        next_misoOut = rdData[7];
        next_shiftOut = {rdData[6:0], 1'b0};
      end else begin
        next_misoOut = shiftOut[7];
        next_shiftOut = {shiftOut[6:0], 1'b0};
      end
    end
  end

  // Frame state registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bitCount <= '0;
      shiftIn <= '0;
      shiftOut <= '0;
      access <= '0;
      writeStb <= 1'b0;
      misoOut <= 1'b0;
      misoOe <= 1'b0;
    end else begin
      bitCount <= next_bitCount;
      shiftIn <= next_shiftIn;
      shiftOut <= next_shiftOut;
      access <= next_access;
      writeStb <= next_writeStb;
      misoOut <= next_misoOut;
      misoOe <= next_misoOe;
    end
  end

endmodule : spi_frame_slave

// *** logic/can_transceiver_config_status.sv ***
// Configuration and status register group of the CAN transceiver with its steering logic
`timescale 1ns/10ps
module can_transceiver_config_status #(
  parameter bit HAS_SECONDARY = 1'b1,
  parameter int SILENCE_US = 1000000,
  parameter int CLAMP_US = 4000
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic startupDone,
  input wire logic sckPin,
  input wire logic csPin_n,
  input wire logic mosiPin,
  output logic misoOut,
  output logic misoOe,
  input wire logic txdPin,
  input wire logic secondary_transmit_in,
  input wire logic busDominantPin,
  input wire logic activeMode,
  input wire logic txReady,
  input wire logic lowPowerMode,
  input wire logic wakeOrPowerOnEvent,
  input wire logic anyEnabledEvent,
  input wire logic gpio1IsSecondaryRx,
  input wire logic gpio2IsSecondaryTx,
  output logic rxdOut,
  output logic secondary_receive_out,
  output logic driveDominant,
  output logic battery_clamp_disable,
  output logic long_uv_timeout_select,
  output logic biasFromLogicSupply,
  output logic low_power_listen_enable,
  output logic wake_pattern_select
);
  import can_cfg_pkg::*;

  // Cycle counts derived from the microsecond figures
  localparam logic [31:0] SILENCE_CYC = 32'(SILENCE_US * CLK_MHZ);
  localparam logic [31:0] CLAMP_CYC = 32'(CLAMP_US * CLK_MHZ);
  localparam logic [7:0] BUS_WR_MASK = HAS_SECONDARY ? BUS_CFG_MASK
                                                     : (BUS_CFG_MASK & ~BUS_CFG_SEC_BIT);

  sys_cfg_t sysCfg;
  bus_cfg_t busCfg;
  sys_cfg_t next_sysCfg;
  bus_cfg_t next_busCfg;
  bus_stat_t busStat;
  reg_access_t access;
  logic writeStb;
  logic [7:0] rdData;
  logic [1:0] txdSync;
  logic [1:0] txd2Sync;
  logic [1:0] busSync;
  logic [DET_N-1:0] detLevel;
  logic [DET_N-1:0] detFlag;
  logic secLoopOn;
  logic next_rxdOut;
  logic next_rxd2Out;
  logic next_driveDominant;

  // Register interface framing lives in the serial slave
  spi_frame_slave spi_frame_slave_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .sckPin(sckPin),
    .csPin_n(csPin_n),
    .mosiPin(mosiPin),
    .rdData(rdData),
    .access(access),
    .writeStb(writeStb),
    .misoOut(misoOut),
    .misoOe(misoOe)
  );

  // Pin synchronisers for the transmit inputs and the bus comparator
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txdSync <= 2'b11;
      txd2Sync <= 2'b11;
      busSync <= '0;
    end else begin
      txdSync <= {txdSync[0], txdPin};
      txd2Sync <= {txd2Sync[0], secondary_transmit_in};
      busSync <= {busSync[0], busDominantPin};
    end
  end

  // Config writes; reserved bits are masked so they always read zero
  always_comb begin
    next_sysCfg = sysCfg;
    next_busCfg = busCfg;
    if (!startupDone) begin
      // Defaults are held until startup has completed
      next_sysCfg = sys_cfg_t'(SYS_CFG_RESET);
      next_busCfg = bus_cfg_t'(BUS_CFG_RESET);
    end else if (writeStb) begin
      if (access.addr == ADDR_SYS_CFG) begin
        next_sysCfg = sys_cfg_t'(access.data & SYS_CFG_MASK);
      end
      if (access.addr == ADDR_BUS_CFG) begin
        next_busCfg = bus_cfg_t'(access.data & BUS_WR_MASK);
      end
    end
  end

  // Config registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sysCfg <= sys_cfg_t'(SYS_CFG_RESET);
      busCfg <= bus_cfg_t'(BUS_CFG_RESET);
    end else begin
      sysCfg <= next_sysCfg;
      busCfg <= next_busCfg;
    end
  end

  // Detector inputs: silence is a long recessive bus, clamps are long dominant levels
  assign detLevel[DET_SILENCE] = ~busSync[1];
  assign detLevel[DET_BUS] = busSync[1];
  assign detLevel[DET_TX] = ~txdSync[1];
  assign detLevel[DET_TX2] = HAS_SECONDARY & gpio2IsSecondaryTx & ~txd2Sync[1];

  // Stuck-level timers; flag rises at the limit and drops as soon as the level ends
  for (genvar i = 0; i < DET_N; i++) begin : gDet
    localparam logic [31:0] LIMIT = (i == DET_SILENCE) ? SILENCE_CYC : CLAMP_CYC;
    logic [31:0] count;
    logic [31:0] next_count;

    always_comb begin
      next_count = '0;
      if (detLevel[i]) begin
        next_count = (count == LIMIT) ? count : count + 32'h0000_0001;
      end
    end

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        count <= '0;
      end else begin
        count <= next_count;
      end
    end

    assign detFlag[i] = (count == LIMIT);
  end

  // Status view, a live reflection of the block state
  always_comb begin
    busStat = '0;
    busStat.readyToTransmit = activeMode & txReady;
    busStat.busSilenceFlag = detFlag[DET_SILENCE];
    busStat.busClampedFlag = detFlag[DET_BUS];
    busStat.secondaryTxClampedFlag = HAS_SECONDARY & detFlag[DET_TX2];
    busStat.primaryTxClampedFlag = detFlag[DET_TX];
  end

  // Read decode; unmapped addresses read zero, status ignores writes
  always_comb begin
    unique case (access.addr)
      ADDR_SYS_CFG: rdData = sysCfg;
      ADDR_BUS_CFG: rdData = busCfg;
      ADDR_BUS_STAT: rdData = busStat;
      default: rdData = READ_UNMAPPED;
    endcase
  end

  // Secondary loopback needs both general pins set up as secondary pins
  assign secLoopOn = HAS_SECONDARY & busCfg.secondaryLoopbackEnable
                     & gpio1IsSecondaryRx & gpio2IsSecondaryTx;

  // Receive-side and transmit-side steering
  always_comb begin
    if (lowPowerMode) begin
      // Receive pin goes low to flag a pending event
      next_rxdOut = sysCfg.receivePinIrqSelect ? ~anyEnabledEvent
                                               : ~wakeOrPowerOnEvent;
    end else if (busCfg.localLoopbackEnable) begin
      next_rxdOut = txdSync[1];
    end else begin
      next_rxdOut = ~busSync[1];
    end
    next_rxd2Out = secLoopOn ? txd2Sync[1] : ~busSync[1];
    // A clamped primary input is kept off the bus so it cannot block traffic
    next_driveDominant = activeMode & ~busCfg.localLoopbackEnable & ~secLoopOn
                         & ((~txdSync[1] & ~detFlag[DET_TX]) | detLevel[DET_TX2]);
  end

  // Registered pin and control outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxdOut <= 1'b1;
      secondary_receive_out <= 1'b1;
      driveDominant <= 1'b0;
      battery_clamp_disable <= 1'b0;
      long_uv_timeout_select <= 1'b1;
      biasFromLogicSupply <= 1'b0;
      low_power_listen_enable <= 1'b0;
      wake_pattern_select <= 1'b0;
    end else begin
      rxdOut <= next_rxdOut;
      secondary_receive_out <= next_rxd2Out;
      driveDominant <= next_driveDominant;
      battery_clamp_disable <= sysCfg.batteryClampDisable;
      long_uv_timeout_select <= sysCfg.longUvTimeoutSelect;
      biasFromLogicSupply <= sysCfg.supplyArrangementSelect;
      low_power_listen_enable <= busCfg.lowPowerListenEnable;
      wake_pattern_select <= busCfg.wakePatternSelect;
    end
  end

endmodule : can_transceiver_config_status

// *** sim/can_cfg_sva.sv ***
// Checker: port-level relations of the config and steering block
`timescale 1ns/10ps
module can_cfg_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic startupDone,
  input wire logic csPin_n,
  input wire logic misoOe,
  input wire logic txdPin,
  input wire logic secondary_transmit_in,
  input wire logic busDominantPin,
  input wire logic lowPowerMode,
  input wire logic wakeOrPowerOnEvent,
  input wire logic anyEnabledEvent,
  input wire logic gpio1IsSecondaryRx,
  input wire logic rxdOut,
  input wire logic secondary_receive_out,
  input wire logic driveDominant,
  input wire logic battery_clamp_disable,
  input wire logic long_uv_timeout_select,
  input wire logic biasFromLogicSupply,
  input wire logic low_power_listen_enable,
  input wire logic wake_pattern_select
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Config copies packed so defaults are one compare
  logic [4:0] cfg;
  assign cfg = {battery_clamp_disable, long_uv_timeout_select, biasFromLogicSupply,
    low_power_listen_enable, wake_pattern_select};
  // Four cycles give the pin synchronisers time to flush
  sequence csIdle;
    csPin_n [*4];
  endsequence
  sequence csBusy;
    !csPin_n [*4];
  endsequence
  sequence quiet;
    (csPin_n && startupDone) [*8];
  endsequence
  sequence pinsRecessive;
    (txdPin && secondary_transmit_in) [*4];
  endsequence
  AST_RESET_DEFAULTS: assert property ($fell(sys_rst) |-> cfg == 5'h08)
    else $error("config not at defaults after reset");
  AST_STARTUP_DEFAULTS: assert property (!startupDone [*2] |-> cfg == 5'h08)
    else $error("config not held at defaults before startup");
  AST_CFG_QUIET: assert property (quiet |-> $stable(cfg))
    else $error("config changed without a frame");
  AST_MISO_OFF: assert property (csIdle |-> !misoOe)
    else $error("serial output driven while deselected");
  AST_MISO_ON: assert property (csBusy |-> misoOe)
    else $error("serial output not driven while selected");
  AST_RXD_EVENT: assert property ((lowPowerMode && wakeOrPowerOnEvent == anyEnabledEvent
    && $stable(anyEnabledEvent)) [*2] |-> rxdOut == !anyEnabledEvent)
    else $error("receive pin does not show event");
  AST_NO_DRIVE: assert property (pinsRecessive |-> !driveDominant)
    else $error("dominant drive with recessive inputs");
  AST_RX2_BUS: assert property ((!gpio1IsSecondaryRx && $stable(busDominantPin)) [*4]
    |-> secondary_receive_out == !busDominantPin)
    else $error("secondary receive not following bus");
endmodule : can_cfg_sva

// *** sim/host_mcu_model.sv ***
// Host model: drives serial register frames and collects read data
`timescale 1ns/10ps
module host_mcu_model (
  input wire logic clk,
  input wire logic misoOut,
  input wire logic misoOe,
  output logic sckPin,
  output logic csPin_n,
  output logic mosiPin
);
  // Idle: SCK low, nothing selected
  initial begin
    sckPin = 1'b0;
    csPin_n = 1'b1;
    mosiPin = 1'b0;
  end
  // 24-bit frame, 8 clocks per SCK period; data moves on falls, read bits taken on rises
  task automatic xfer(input logic [11:0] a, input logic rd, input logic [7:0] wd,
    output logic [7:0] rdv);
    logic [23:0] frame;
    frame = {a, 3'h0, rd, wd};
    rdv = 8'h00;
    @(posedge clk);
    csPin_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      sckPin <= 1'b0;
      mosiPin <= frame[i];
      repeat (4) @(posedge clk);
      sckPin <= 1'b1;
      rdv = {rdv[6:0], misoOe ? misoOut : 1'bx}; // Undriven line must not pass
    end
    repeat (4) @(posedge clk);
    sckPin <= 1'b0;
    repeat (4) @(posedge clk);
    csPin_n <= 1'b1;
    mosiPin <= ~frame[0]; // Released data line does not keep the last bit
    repeat (8) @(posedge clk);
  endtask : xfer
endmodule : host_mcu_model

// *** sim/can_transceiver_config_status_tb_top.sv ***
// Testbench: startup, then register rows, status, steering and reset cases
`timescale 1ns/10ps
module can_transceiver_config_status_tb_top;
  import can_cfg_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [7:0] outs;
  } row_t;
  logic clk, sys_rst, startupDone, sckPin, csPin_n, mosiPin, misoOut, misoOe;
  logic txdPin, secondary_transmit_in, busDominantPin, activeMode, txReady, lowPowerMode;
  logic wakeOrPowerOnEvent, anyEnabledEvent, gpio1IsSecondaryRx, gpio2IsSecondaryTx;
  logic rxdOut, secondary_receive_out, driveDominant, battery_clamp_disable;
  logic long_uv_timeout_select, biasFromLogicSupply, low_power_listen_enable;
  logic wake_pattern_select;
  logic [7:0] cfgOuts;
  int nErrors = 0;
  int samplesChecked = 0;
  int cycles = 0;
  // Reserved bits set on purpose; they must read back as zero
  row_t rows [6] = '{
    '{ADDR_SYS_CFG, 8'hFF, 8'h0F, 8'h1C},
    '{ADDR_SYS_CFG, 8'h05, 8'h05, 8'h04},
    '{ADDR_BUS_CFG, 8'hFF, 8'h33, 8'h07},
    '{ADDR_BUS_CFG, 8'h21, 8'h21, 8'h05},
    '{12'h123, 8'h55, READ_UNMAPPED, 8'h05},
    '{ADDR_SYS_CFG, 8'h0A, 8'h0A, 8'h19}
  };
  assign cfgOuts = {3'h0, battery_clamp_disable, long_uv_timeout_select,
    biasFromLogicSupply, low_power_listen_enable, wake_pattern_select};
  // Slow detectors shortened so clamp and silence fit the run
  can_transceiver_config_status #(.SILENCE_US(5), .CLAMP_US(2))
    can_transceiver_config_status_i (.*);
  host_mcu_model host_mcu_model_i (.*);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask : chk1
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] v;
    host_mcu_model_i.xfer(a, 1'b0, d, v);
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] v;
    host_mcu_model_i.xfer(a, 1'b1, 8'h00, v);
    chk(v, e);
  endtask : rdchk
  // Pin synchronisers plus output register need a few cycles
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask : settle
  task automatic conclude();
    $display("checks %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      nErrors++;
      conclude();
    end
  end
  initial begin
    sys_rst = 1'b1;
    startupDone = 1'b0;
    {txdPin, secondary_transmit_in, activeMode, txReady} = 4'hF;
    {busDominantPin, lowPowerMode, wakeOrPowerOnEvent, anyEnabledEvent} = 4'h0;
    {gpio1IsSecondaryRx, gpio2IsSecondaryTx} = 2'h0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    wr(ADDR_SYS_CFG, 8'h0F);
    rdchk(ADDR_SYS_CFG, SYS_CFG_RESET);
    chk(cfgOuts, 8'h08);
    $display("startup done");
    startupDone <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(rows[i].a, rows[i].wd);
      rdchk(rows[i].a, rows[i].rd);
      chk(cfgOuts, rows[i].outs);
    end
    $display("rows done");
    wr(ADDR_BUS_STAT, 8'h00);
    rdchk(ADDR_BUS_STAT, 8'h88);
    txReady <= 1'b0;
    rdchk(ADDR_BUS_STAT, 8'h08);
    txReady <= 1'b1;
    activeMode <= 1'b0;
    busDominantPin <= 1'b1;
    repeat (60) @(posedge clk);
    rdchk(ADDR_BUS_STAT, 8'h04);
    txdPin <= 1'b0;
    secondary_transmit_in <= 1'b0;
    gpio2IsSecondaryTx <= 1'b1;
    repeat (60) @(posedge clk);
    rdchk(ADDR_BUS_STAT, 8'h07);
    {txdPin, secondary_transmit_in, activeMode, busDominantPin, gpio2IsSecondaryTx} <= 5'h1C;
    settle();
    $display("status done");
    txdPin <= 1'b0;
    settle();
    chk1(rxdOut, 1'b0);
    chk1(driveDominant, 1'b0);
    txdPin <= 1'b1;
    wr(ADDR_BUS_CFG, 8'h00);
    txdPin <= 1'b0;
    settle();
    chk1(driveDominant, 1'b1);
    chk1(rxdOut, 1'b1);
    txdPin <= 1'b1;
    wr(ADDR_BUS_CFG, 8'h10);
    {gpio1IsSecondaryRx, gpio2IsSecondaryTx, secondary_transmit_in} <= 3'h6;
    settle();
    chk1(secondary_receive_out, 1'b0);
    chk1(driveDominant, 1'b0);
    gpio1IsSecondaryRx <= 1'b0;
    settle();
    chk1(secondary_receive_out, 1'b1);
    {gpio2IsSecondaryTx, secondary_transmit_in} <= 2'h1;
    $display("loopback done");
    lowPowerMode <= 1'b1;
    anyEnabledEvent <= 1'b1;
    settle();
    chk1(rxdOut, 1'b1);
    wr(ADDR_SYS_CFG, 8'h0E);
    chk1(rxdOut, 1'b0);
    wakeOrPowerOnEvent <= 1'b1;
    settle();
    chk1(rxdOut, 1'b0);
    {lowPowerMode, wakeOrPowerOnEvent, anyEnabledEvent} <= 3'h0;
    $display("events done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    rdchk(ADDR_SYS_CFG, SYS_CFG_RESET);
    rdchk(ADDR_BUS_CFG, BUS_CFG_RESET);
    $display("reset done");
    conclude();
  end
endmodule : can_transceiver_config_status_tb_top
bind can_transceiver_config_status can_cfg_sva can_cfg_sva_i (.*);
